// ==== design/fsg_pkg.sv ====
// Package: offsets, field positions, reset values and address map
`default_nettype none
package fsg_pkg;
   // SFR addresses
   localparam logic [7:0]  FSG_ADDR_FLSC    = 8'hB6;
   localparam logic [7:0]  FSG_ADDR_PSC     = 8'h8F;
   localparam logic [7:0]  FSG_ADDR_LIMIT   = 8'hB7;
   // Reset values
   localparam logic [7:0]  FSG_RST_FLSC     = 8'h80;
   localparam logic [7:0]  FSG_RST_PSC      = 8'h00;
   localparam logic [7:0]  FSG_RST_LIMIT    = 8'h00;
   localparam logic [7:0]  FSG_RST_LOCK     = 8'hFF;
   // Field positions
   localparam int          FSG_BIT_UFWE     = 0;
   localparam int          FSG_BIT_SWE      = 0;
   localparam int          FSG_BIT_SEE      = 1;
   localparam int          FSG_BIT_SFLE     = 2;
   localparam logic [7:0]  FSG_FLSC_WMASK   = 8'hC1;
   localparam logic [7:0]  FSG_PSC_WMASK    = 8'h07;
   // Flash map
   localparam logic [15:0] FSG_RLOCK_ADDR   = 16'hFDFF;
   localparam logic [15:0] FSG_WLOCK_ADDR   = 16'hFDFE;
   localparam logic [6:0]  FSG_LOCK_PAGE    = 7'h7E;
   localparam int          FSG_BLK_MSB      = 15;
   localparam int          FSG_BLK_LSB      = 13;
   localparam int          FSG_PAGE_LSB     = 9;
   localparam logic [7:0]  FSG_ZERO_BYTE    = 8'h00;
   localparam logic [7:0]  FSG_UNDEF_BYTE   = 8'hFF;
endpackage : fsg_pkg
`default_nettype wire

// ==== design/fsg_guard.sv ====
// Flash security guard: write/erase enables, JTAG locks, read limit
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// How it works
// - Software write needs both write enables; erase also needs erase enable
// - Each lock bit guards one 8k block
// - Read lock byte at 0xFDFF gates reads
// - Write lock byte at 0xFDFE gates writes
// - Scratchpad locked only when all blocks locked
// - Lock page: software write ok, erase refused
// - Read-locked JTAG read gives undefined data
// - Lock bits always readable and clearable
// - Only reset, JTAG mass erase or JTAG lock page erase removes locks
// - JTAG erase of lock byte: mass erase
// - Other lock page JTAG erase: page only
// - Read limit splits lower and upper partition
// - Upper MOVC of lower address returns zero
// - Upper code may fetch lower instructions
// - Lower code reads everything freely
// - Limit address is register byte then zero
// - Limit resets to zero, all readable
// - User flash write enable gates software writes and erases
// ---------------------------------------------------------------
module fsg_guard
   import fsg_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // SFR access from the core
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   output var  logic [7:0]  sfr_rdata,
   // Core MOVX flash write/erase request
   input  wire logic        cpu_wr_req,
   input  wire logic [15:0] cpu_wr_addr,
   input  wire logic [7:0]  cpu_wr_data,
   // Core MOVC read and opcode fetch
   input  wire logic        movc_req,
   input  wire logic        fetch_req,
   input  wire logic [15:0] cpu_pc,
   input  wire logic [15:0] cpu_rd_addr,
   // JTAG programmer requests
   input  wire logic        jtag_rd_req,
   input  wire logic        jtag_wr_req,
   input  wire logic        jtag_er_req,
   input  wire logic [15:0] jtag_addr,
   input  wire logic [7:0]  jtag_wdata,
   input  wire logic        jtag_dbg_req,
   // Flash array port
   input  wire logic [7:0]  flash_rdata,
   output var  logic        fl_wr,
   output var  logic        fl_page_er,
   output var  logic        fl_mass_er,
   output var  logic        fl_scratch,
   output var  logic [15:0] fl_addr,
   output var  logic [7:0]  fl_wdata,
   // Read data back to core and JTAG
   output var  logic [7:0]  cpu_rdata,
   output var  logic        cpu_rvalid,
   output var  logic [7:0]  jtag_rdata,
   output var  logic        jtag_rvalid,
   output var  logic        fetch_ok,
   output var  logic        dbg_allow,
   output var  logic        jtag_refused
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic lock_open(input logic [7:0]  lock,
                                      input logic [15:0] a,
                                      input logic        scr);
      // Scratchpad counts locked only when every block is locked
      if (scr)
         return (lock != FSG_ZERO_BYTE);
      return lock[a[FSG_BLK_MSB:FSG_BLK_LSB]];
   endfunction

   function automatic logic is_lock_byte(input logic [15:0] a);
      return (a == FSG_RLOCK_ADDR) || (a == FSG_WLOCK_ADDR);
   endfunction

   function automatic logic in_lock_page(input logic [15:0] a);
      return a[FSG_BLK_MSB:FSG_PAGE_LSB] == FSG_LOCK_PAGE;
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  flsc_r;
   logic [7:0]  psc_r;
   logic [7:0]  limit_r;
   logic [7:0]  rlock_r;
   logic [7:0]  wlock_r;
   logic [15:0] limit_addr;
   logic        sw_ok;
   logic        scr_sel;

   assign limit_addr = {limit_r, FSG_ZERO_BYTE};
   assign scr_sel    = psc_r[FSG_BIT_SFLE];
   assign sw_ok      = flsc_r[FSG_BIT_UFWE] &
                       psc_r[FSG_BIT_SWE];

   // Flash control: only the user write enable and read bits are kept
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         flsc_r <= FSG_RST_FLSC;
      end else if (sfr_wr && sfr_addr == FSG_ADDR_FLSC) begin
         flsc_r <= sfr_wdata & FSG_FLSC_WMASK;
      end
   end

   // Program store control: write, erase and scratchpad select
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         psc_r <= FSG_RST_PSC;
      end else if (sfr_wr && sfr_addr == FSG_ADDR_PSC) begin
         psc_r <= sfr_wdata & FSG_PSC_WMASK;
      end
   end

   // Read limit byte: zero after reset leaves all memory readable
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         limit_r <= FSG_RST_LIMIT;
      end else if (sfr_wr && sfr_addr == FSG_ADDR_LIMIT) begin
         limit_r <= sfr_wdata;
      end
   end

   // Register read back, registered one cycle after the strobe

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata <= FSG_ZERO_BYTE;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            FSG_ADDR_FLSC:  sfr_rdata <= flsc_r;
            FSG_ADDR_PSC:   sfr_rdata <= psc_r;
            FSG_ADDR_LIMIT: sfr_rdata <= limit_r;
            default:        sfr_rdata <= FSG_ZERO_BYTE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Lock byte shadows
   // ------------------------------------------------------------
   // Writes only clear bits (flash AND); only reset and erases set them again
   logic cpu_lock_wr;
   logic jtag_lock_wr;
   logic mass_er;
   logic page_er_lock;
   assign cpu_lock_wr  = cpu_wr_req & sw_ok & ~psc_r[FSG_BIT_SEE] &
                         ~scr_sel & is_lock_byte(cpu_wr_addr);
   assign jtag_lock_wr = jtag_wr_req & is_lock_byte(jtag_addr);
   assign mass_er      = jtag_er_req & is_lock_byte(jtag_addr);
   assign page_er_lock = jtag_er_req & ~is_lock_byte(jtag_addr) &
                         in_lock_page(jtag_addr) &
                         wlock_r[jtag_addr[FSG_BLK_MSB:FSG_BLK_LSB]];

   // Read lock shadow: erase restores all ones, writes only clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rlock_r <= FSG_RST_LOCK;
      end else if (mass_er || page_er_lock) begin
         rlock_r <= FSG_RST_LOCK;
      end else begin
         if (cpu_lock_wr && cpu_wr_addr == FSG_RLOCK_ADDR)
            rlock_r <= rlock_r & cpu_wr_data;
         if (jtag_lock_wr && jtag_addr == FSG_RLOCK_ADDR)
            rlock_r <= rlock_r & jtag_wdata;
      end
   end

   // Write/erase lock shadow: same erase and clear behaviour
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wlock_r <= FSG_RST_LOCK;
      end else if (mass_er || page_er_lock) begin
         wlock_r <= FSG_RST_LOCK;
      end else begin
         if (cpu_lock_wr && cpu_wr_addr == FSG_WLOCK_ADDR)
            wlock_r <= wlock_r & cpu_wr_data;
         if (jtag_lock_wr && jtag_addr == FSG_WLOCK_ADDR)
            wlock_r <= wlock_r & jtag_wdata;
      end
   end

   // ------------------------------------------------------------
   // Flash command arbitration
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fl_wr        <= 1'b0;
         fl_page_er   <= 1'b0;
         fl_mass_er   <= 1'b0;
         fl_scratch   <= 1'b0;
         fl_addr      <= 16'h0000;
         fl_wdata     <= FSG_ZERO_BYTE;
         jtag_refused <= 1'b0;
      end else begin
         fl_wr        <= 1'b0;
         fl_page_er   <= 1'b0;
         fl_mass_er   <= 1'b0;
         fl_scratch   <= 1'b0;
         jtag_refused <= 1'b0;
         if (jtag_er_req) begin
            fl_addr <= jtag_addr;
            if (mass_er) begin
               fl_mass_er <= 1'b1;
            end else if (in_lock_page(jtag_addr) && page_er_lock) begin
               fl_page_er <= 1'b1;
            end else if (lock_open(wlock_r, jtag_addr, 1'b0) &&
                         !in_lock_page(jtag_addr)) begin
               fl_page_er <= 1'b1;
            end else begin
               jtag_refused <= 1'b1;
            end
         end else if (jtag_wr_req) begin
            fl_addr  <= jtag_addr;
            fl_wdata <= jtag_wdata;
            if (is_lock_byte(jtag_addr) ||
                lock_open(wlock_r, jtag_addr, 1'b0))
               fl_wr <= 1'b1;
            else
               jtag_refused <= 1'b1;
         end else if (cpu_wr_req && sw_ok) begin
            fl_addr    <= cpu_wr_addr;
            fl_wdata   <= cpu_wr_data;
            fl_scratch <= scr_sel;
            if (psc_r[FSG_BIT_SEE]) begin
               // Lock page cannot be erased by software
               if (scr_sel || !in_lock_page(cpu_wr_addr))
                  fl_page_er <= 1'b1;
            end else begin
               fl_wr <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Read filtering
   // ------------------------------------------------------------
   logic pc_upper;
   logic src_lower;
   assign pc_upper  = cpu_pc >= limit_addr;
   assign src_lower = cpu_rd_addr < limit_addr;

   // MOVC answer strobe
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_rvalid <= 1'b0;
      end else begin
         cpu_rvalid <= movc_req;
      end
   end

   // Opcode fetch is never restricted by the read limit
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fetch_ok <= 1'b0;
      end else begin
         fetch_ok <= fetch_req;
      end
   end

   // MOVC data: upper code reading the lower partition sees zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_rdata <= FSG_ZERO_BYTE;
      end else if (movc_req) begin
         if (!scr_sel && pc_upper && src_lower)
            cpu_rdata <= FSG_ZERO_BYTE;
         else
            cpu_rdata <= flash_rdata;
      end
   end

   // ------------------------------------------------------------
   // JTAG read and debug gating
   // ------------------------------------------------------------
   // JTAG answer strobe
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         jtag_rvalid <= 1'b0;
      end else begin
         jtag_rvalid <= jtag_rd_req;
      end
   end

   // Debug only while the executing block is read-unlocked
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dbg_allow <= 1'b0;
      end else begin
         dbg_allow <= jtag_dbg_req &
                      lock_open(rlock_r, cpu_pc, 1'b0);
      end
   end

   // JTAG data: lock bytes always visible, locked blocks hidden
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         jtag_rdata <= FSG_ZERO_BYTE;
      end else begin
         if (jtag_rd_req) begin
            if (jtag_addr == FSG_RLOCK_ADDR)
               jtag_rdata <= rlock_r;
            else if (jtag_addr == FSG_WLOCK_ADDR)
               jtag_rdata <= wlock_r;
            else if (lock_open(rlock_r, jtag_addr, scr_sel))
               jtag_rdata <= flash_rdata;
            else
               jtag_rdata <= FSG_UNDEF_BYTE;
         end
      end
   end

endmodule // fsg_guard
`default_nettype wire

// ==== tb/fsg_flash_model.sv ====
// Flash array model: byte pattern derived from the address
`timescale 1ns/1ps
`default_nettype none
module fsg_flash_model (
   // Array read port
   input  wire logic [15:0] rd_addr,
   output var  logic [7:0]  rd_data
);
   // Pattern differs per byte so misrouted data shows
   assign rd_data = rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h5A;
endmodule // fsg_flash_model
`default_nettype wire

// ==== tb/fsg_guard_chk.sv ====
// Checker: port relations of the flash guard
`timescale 1ns/1ps
`default_nettype none
module fsg_guard_chk (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // Requests
   input wire logic        cpu_wr_req,
   input wire logic        movc_req,
   input wire logic [15:0] cpu_pc,
   input wire logic [15:0] cpu_rd_addr,
   input wire logic        jtag_rd_req,
   input wire logic        jtag_wr_req,
   input wire logic        jtag_er_req,
   input wire logic [15:0] jtag_addr,
   input wire logic [7:0]  flash_rdata,
   // Responses
   input wire logic        fl_wr,
   input wire logic        fl_page_er,
   input wire logic        fl_mass_er,
   input wire logic [7:0]  cpu_rdata,
   input wire logic        cpu_rvalid,
   input wire logic        jtag_rvalid,
   input wire logic        jtag_refused
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ------------------------------------------
   // Properties
   // ------------------------------------------
   sequence lock_erase_s;
      jtag_er_req && jtag_addr[15:1] == 15'h7EFF;
   endsequence
   sequence free_movc_s;
      movc_req && cpu_rd_addr >= cpu_pc;
   endsequence
   mass_erase_a: assert property (lock_erase_s |=> fl_mass_er)
      else $error("lock byte erase gave no mass erase");
   mass_src_a: assert property (fl_mass_er |-> $past(jtag_er_req))
      else $error("mass erase without a JTAG erase");
   free_read_a: assert property (free_movc_s |=>
      cpu_rvalid && cpu_rdata == $past(flash_rdata))
      else $error("unrestricted read altered");
   jtag_read_a: assert property (jtag_rd_req |=> jtag_rvalid)
      else $error("JTAG read gave no answer");
   one_erase_a: assert property (!(fl_mass_er && fl_page_er))
      else $error("page and mass erase together");
   write_src_a: assert property (fl_wr |->
      $past(jtag_wr_req) || $past(cpu_wr_req))
      else $error("flash write without request");
   refuse_idle_a: assert property (jtag_refused |->
      !fl_wr && !fl_page_er && !fl_mass_er)
      else $error("refused request still acted");
   cpu_no_mass_a: assert property (cpu_wr_req && !jtag_er_req |=>
      !fl_mass_er)
      else $error("software reached mass erase");
endmodule // fsg_guard_chk
bind fsg_guard fsg_guard_chk i_fsg_guard_chk (
   .core_clk(core_clk), .nrst(nrst), .cpu_wr_req(cpu_wr_req),
   .movc_req(movc_req), .cpu_pc(cpu_pc), .cpu_rd_addr(cpu_rd_addr),
   .jtag_rd_req(jtag_rd_req), .jtag_wr_req(jtag_wr_req),
   .jtag_er_req(jtag_er_req), .jtag_addr(jtag_addr),
   .flash_rdata(flash_rdata), .fl_wr(fl_wr), .fl_page_er(fl_page_er),
   .fl_mass_er(fl_mass_er), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
   .jtag_rvalid(jtag_rvalid), .jtag_refused(jtag_refused));
`default_nettype wire

// ==== tb/fsg_guard_bench.sv ====
// Testbench: register, CPU and JTAG scenarios for the flash guard
`timescale 1ns/1ps
`default_nettype none
module fsg_guard_bench;
   import fsg_pkg::*;
   localparam logic [7:0] SW = 8'h80, SR = 8'h40, CW = 8'h20, MV = 8'h10;
   localparam logic [7:0] FE = 8'h08, JR = 8'h04, JW = 8'h02, JE = 8'h01;
   logic        core_clk, nrst, dbg, fl_wr, fl_page_er, fl_mass_er;
   logic        fl_scratch, cpu_rvalid, jtag_rvalid, fetch_ok;
   logic        dbg_allow, jtag_refused;
   logic [7:0]  rq, dt, sfr_rdata, cpu_rdata, jtag_rdata, frd, fl_wdata;
   logic [15:0] ad, pc, fl_addr;
   logic [3:0]  fst;
   int          err_count, total_checks;
   int          cycles = 0;
   assign fst = {fl_wr, fl_page_er, fl_mass_er, jtag_refused};
   fsg_flash_model i_fsg_flash_model (.rd_addr(ad), .rd_data(frd));
   fsg_guard i_fsg_guard (
      .core_clk(core_clk), .nrst(nrst), .sfr_wr(rq[7]), .sfr_rd(rq[6]),
      .sfr_addr(ad[7:0]), .sfr_wdata(dt), .sfr_rdata(sfr_rdata),
      .cpu_wr_req(rq[5]), .cpu_wr_addr(ad), .cpu_wr_data(dt),
      .movc_req(rq[4]), .fetch_req(rq[3]), .cpu_pc(pc), .cpu_rd_addr(ad),
      .jtag_rd_req(rq[2]), .jtag_wr_req(rq[1]), .jtag_er_req(rq[0]),
      .jtag_addr(ad), .jtag_wdata(dt), .jtag_dbg_req(dbg),
      .flash_rdata(frd), .fl_wr(fl_wr), .fl_page_er(fl_page_er),
      .fl_mass_er(fl_mass_er), .fl_scratch(fl_scratch), .fl_addr(fl_addr),
      .fl_wdata(fl_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
      .jtag_rdata(jtag_rdata), .jtag_rvalid(jtag_rvalid),
      .fetch_ok(fetch_ok), .dbg_allow(dbg_allow),
      .jtag_refused(jtag_refused));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         err_count = err_count + 1;
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic go(input logic [7:0] r, input logic [15:0] a,
                     input logic [7:0] d);
      @(posedge core_clk);
      rq <= r;
      ad <= a;
      dt <= d;
      @(posedge core_clk);
      rq <= 8'h00;
      #1;
   endtask
   task automatic sr(input logic [15:0] a, input logic [7:0] e);
      go(SR, a, 8'h00);
      chk(sfr_rdata, e);
   endtask
   task automatic op(input logic [7:0] r, input logic [15:0] a,
                     input logic [3:0] e);
      go(r, a, 8'h00);
      chk(fst, e);
   endtask
   task automatic mv(input logic [15:0] p, a, input logic [7:0] e);
      @(posedge core_clk);
      pc <= p;
      go(MV, a, 8'h00);
      chk({cpu_rvalid, cpu_rdata}, {1'b1, e});
   endtask
   task automatic jr(input logic [15:0] a, input logic [7:0] e);
      go(JR, a, 8'h00);
      chk({jtag_rvalid, jtag_rdata}, {1'b1, e});
   endtask
   function automatic logic [7:0] fd(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   initial begin
      nrst = 1'b0;
      rq = 8'h00;
      ad = 16'h0000;
      dt = 8'h00;
      pc = 16'h0000;
      dbg = 1'b0;
      err_count = 0;
      total_checks = 0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      sr(16'h00B6, 8'h80);
      sr(16'h008F, 8'h00);
      sr(16'h00B7, 8'h00);
      go(SW, 16'h00B6, 8'hFF);
      sr(16'h00B6, 8'hC1);
      op(CW, 16'h1000, 4'h0);
      go(SW, 16'h008F, 8'h01);
      op(CW, 16'h1000, 4'h8);
      chk(fl_addr, 16'h1000);
      go(SW, 16'h00B6, 8'h80);
      op(CW, 16'h1000, 4'h0);
      go(SW, 16'h00B6, 8'h01);
      go(SW, 16'h008F, 8'h03);
      op(CW, 16'hFC10, 4'h0);
      op(CW, 16'h1000, 4'h4);
      go(SW, 16'h008F, 8'h01);
      op(CW, 16'hFC10, 4'h8);
      go(SW, 16'h008F, 8'h05);
      go(CW, 16'h0010, 8'h3C);
      chk(fl_wdata, 8'h3C);
      chk({fl_scratch, fl_wr}, 2'h3);
      go(SW, 16'h008F, 8'h00);
      mv(16'h8000, 16'h0100, fd(16'h0100));
      go(SW, 16'h00B7, 8'h40);
      mv(16'h8000, 16'h0100, 8'h00);
      mv(16'h8000, 16'h3FFF, 8'h00);
      mv(16'h8000, 16'h4000, fd(16'h4000));
      mv(16'h4000, 16'h4100, fd(16'h4100));
      mv(16'h1000, 16'h0100, fd(16'h0100));
      go(FE, 16'h0100, 8'h00);
      chk(fetch_ok, 1'b1);
      go(JW, 16'hFDFE, 8'hFE);
      jr(16'hFDFE, 8'hFE);
      op(JW, 16'h0010, 4'h1);
      op(JW, 16'h2000, 4'h8);
      go(JW, 16'hFDFF, 8'h7F);
      jr(16'hE000, 8'hFF);
      jr(16'hC000, fd(16'hC000));
      go(JW, 16'hFDFF, 8'hFF);
      jr(16'hFDFF, 8'h7F);
      @(posedge core_clk);
      pc <= 16'hE000;
      dbg <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(dbg_allow, 1'b0);
      @(posedge core_clk);
      pc <= 16'hC000;
      repeat (3) @(posedge core_clk);
      chk(dbg_allow, 1'b1);
      op(JE, 16'hFC10, 4'h4);
      jr(16'hFDFF, 8'hFF);
      go(JW, 16'hFDFE, 8'h00);
      op(JE, 16'h2000, 4'h1);
      op(JE, 16'hFDFF, 4'h2);
      jr(16'hFDFE, 8'hFF);
      end_of_test();
   end
endmodule // fsg_guard_bench
`default_nettype wire
